//--- btp_test_port.sv
// boundary test port: tap controller, instruction, bypass and id registers
//
// Contract
// - test reset low forces the port into its reset state at any time.
// - mode select is captured on test clock rising edges to steer states.
// - test data input is sampled on each test clock rising edge.
// - test data output changes on test clock falling edges.
// - test data output floats except while shifting a scan path.
`timescale 1ns/100ps
`default_nettype none
`include "btp_consts.svh"
module btp_test_port (
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   input  wire logic test_clk_i,
   input  wire logic test_mode_sel_i,
   input  wire logic test_data_i,
   input  wire logic test_reset_n_i,
   input  wire logic factory_scan_enable_i,
   output logic      test_data_o,
   output logic      test_data_oe_n_o,
   output logic      port_in_reset_o,
   output logic      scan_fault_o
);
   import btp_pkg::*;

   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic trst_n_s;
   logic fse_s;

   // pin bank order: test clock, mode select, data in, test reset, scan enable
   logic [`BTP_PIN_CNT-1:0] pin_raw;
   logic [`BTP_PIN_CNT-1:0] pin_init;
   logic [`BTP_PIN_CNT-1:0] pin_sync;

   assign pin_raw  = {factory_scan_enable_i, test_reset_n_i, test_data_i, test_mode_sel_i,
                      test_clk_i};
   // flush levels: clock idles low, test reset stays asserted until the pin is seen
   assign pin_init = `BTP_PIN_INIT;

   // the test clock is slow (200 ns) against 25 ns, so sampling finds its edges
   genvar gi;
   generate
      for (gi = 0; gi < `BTP_PIN_CNT; gi = gi + 1) begin : g_sync
         btp_pin_sync u_sync (
            .core_clk_i (core_clk_i),
            .pin_i      (pin_raw[gi]),
            .init_i     (pin_init[gi]),
            .rst_i      (rst_i),
            .sync_o     (pin_sync[gi])
         );
      end
   endgenerate

   assign tck_s    = pin_sync[0];
   assign tms_s    = pin_sync[1];
   assign tdi_s    = pin_sync[2];
   assign trst_n_s = pin_sync[3];
   assign fse_s    = pin_sync[4];

   logic                   tck_d_r;
   logic                   tck_d_nxt;
   btp_state_type          state_r;
   btp_state_type          state_nxt;
   logic [`BTP_IR_W-1:0]   ir_sh_r;
   logic [`BTP_IR_W-1:0]   ir_sh_nxt;
   logic [`BTP_IR_W-1:0]   ir_r;
   logic [`BTP_IR_W-1:0]   ir_nxt;
   logic [`BTP_ID_W-1:0]   dr_sh_r;
   logic [`BTP_ID_W-1:0]   dr_sh_nxt;
   logic                   tdo_r;
   logic                   tdo_nxt;
   logic                   oe_n_r;
   logic                   oe_n_nxt;
   logic                   in_rst_r;
   logic                   in_rst_nxt;
   logic                   fault_r;
   logic                   fault_nxt;
   logic                   rise;
   logic                   fall;
   logic                   shifting;

   assign rise     = tck_s & ~tck_d_r;
   assign fall     = ~tck_s & tck_d_r;
   assign shifting = (state_r == BTP_SHIFT_DR) || (state_r == BTP_SHIFT_IR);

   // the id register sits behind the id instruction; every other code is a one-bit bypass
   function automatic logic id_selected(input logic [`BTP_IR_W-1:0] code);
      id_selected = (code == `BTP_IR_IDCODE);
   endfunction

   // standard state step, shared by the next-state logic
   function automatic btp_state_type step(input btp_state_type s, input logic m);
      case (s)
         BTP_RESET:    step = m ? BTP_RESET  : BTP_IDLE;
         BTP_IDLE:     step = m ? BTP_SEL_DR : BTP_IDLE;
         BTP_SEL_DR:   step = m ? BTP_SEL_IR : BTP_CAP_DR;
         BTP_CAP_DR:   step = m ? BTP_EXIT1_DR : BTP_SHIFT_DR;
         BTP_SHIFT_DR: step = m ? BTP_EXIT1_DR : BTP_SHIFT_DR;
         BTP_EXIT1_DR: step = m ? BTP_UPD_DR : BTP_PAUSE_DR;
         BTP_PAUSE_DR: step = m ? BTP_EXIT2_DR : BTP_PAUSE_DR;
         BTP_EXIT2_DR: step = m ? BTP_UPD_DR : BTP_SHIFT_DR;
         BTP_UPD_DR:   step = m ? BTP_SEL_DR : BTP_IDLE;
         BTP_SEL_IR:   step = m ? BTP_RESET  : BTP_CAP_IR;
         BTP_CAP_IR:   step = m ? BTP_EXIT1_IR : BTP_SHIFT_IR;
         BTP_SHIFT_IR: step = m ? BTP_EXIT1_IR : BTP_SHIFT_IR;
         BTP_EXIT1_IR: step = m ? BTP_UPD_IR : BTP_PAUSE_IR;
         BTP_PAUSE_IR: step = m ? BTP_EXIT2_IR : BTP_PAUSE_IR;
         BTP_EXIT2_IR: step = m ? BTP_UPD_IR : BTP_SHIFT_IR;
         BTP_UPD_IR:   step = m ? BTP_SEL_DR : BTP_IDLE;
         default:      step = BTP_RESET;
      endcase
   endfunction

   // edge detector idles low like the pin, so leaving reset makes no false edge
   always_comb begin
      tck_d_nxt = tck_s;
      if (rst_i) begin
         tck_d_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      tck_d_r <= tck_d_nxt;
   end

   // factory scan enable must stay low; the flag survives test reset on purpose
   always_comb begin
      fault_nxt = fault_r | fse_s;
      if (rst_i) begin
         fault_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      fault_r <= fault_nxt;
   end

   // controller state, instruction and data shift registers
   always_comb begin
      state_nxt  = state_r;
      ir_sh_nxt  = ir_sh_r;
      ir_nxt     = ir_r;
      dr_sh_nxt  = dr_sh_r;
      in_rst_nxt = (state_r == BTP_RESET);
      if (rise) begin
         state_nxt = step(state_r, tms_s);
         case (state_r)
            BTP_CAP_IR:   ir_sh_nxt = `BTP_IR_CAPTURE;
            BTP_SHIFT_IR: ir_sh_nxt = {tdi_s, ir_sh_r[`BTP_IR_W-1:1]};
            BTP_UPD_IR:   ir_nxt    = ir_sh_r;
            BTP_CAP_DR:   dr_sh_nxt = id_selected(ir_r) ? `BTP_IDCODE_VAL : `BTP_ID_W'(0);
            BTP_SHIFT_DR: begin
               // bypass keeps one stage, so the id word never leaks out behind it
               if (id_selected(ir_r)) begin
                  dr_sh_nxt = {tdi_s, dr_sh_r[`BTP_ID_W-1:1]};
               end else begin
                  dr_sh_nxt = {(`BTP_ID_W-1)'(0), tdi_s};
               end
            end
            default: ;
         endcase
      end
      // low or tied pin keeps port reset
      // synchronised, so the reset lands three core cycles after the pin
      if (!trst_n_s) begin
         state_nxt  = BTP_RESET;
         ir_nxt     = `BTP_IR_RESET;
         in_rst_nxt = 1'b1;
      end
      if (rst_i) begin
         state_nxt  = BTP_RESET;
         ir_sh_nxt  = `BTP_IR_RESET;
         ir_nxt     = `BTP_IR_RESET;
         dr_sh_nxt  = `BTP_ID_W'(0);
         in_rst_nxt = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      state_r  <= state_nxt;
      ir_sh_r  <= ir_sh_nxt;
      ir_r     <= ir_nxt;
      dr_sh_r  <= dr_sh_nxt;
      in_rst_r <= in_rst_nxt;
   end

   // pin driver moves only after a test clock fall or floats on test reset, so the next rise sees it settled
   always_comb begin
      tdo_nxt  = tdo_r;
      oe_n_nxt = oe_n_r;
      if (fall) begin
         oe_n_nxt = ~shifting;
         tdo_nxt  = (state_r == BTP_SHIFT_IR) ? ir_sh_r[0] : dr_sh_r[0];
      end
      if (!trst_n_s) begin
         oe_n_nxt = 1'b1;
      end
      if (rst_i) begin
         tdo_nxt  = 1'b0;
         oe_n_nxt = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      tdo_r  <= tdo_nxt;
      oe_n_r <= oe_n_nxt;
   end

   assign test_data_o      = tdo_r;
   assign test_data_oe_n_o = oe_n_r;
   assign port_in_reset_o  = in_rst_r;
   assign scan_fault_o     = fault_r;
endmodule // btp_test_port
`default_nettype wire

//--- btp_consts.svh
// constants for the boundary test port block
`ifndef BTP_CONSTS_SVH
`define BTP_CONSTS_SVH
`define BTP_IR_W        4
`define BTP_IR_RESET    4'h1
`define BTP_IR_BYPASS   4'hf
`define BTP_IR_IDCODE   4'h1
`define BTP_IR_CAPTURE  4'h1
`define BTP_PIN_CNT     5
`define BTP_PIN_INIT    5'h06
`define BTP_IDCODE_VAL  32'h0000_0001
`define BTP_ID_W        32
`define BTP_SYNC_W      2
`define BTP_SYNC_INIT   2'h0
`define BTP_ST_W        16
`endif

//--- btp_pkg.sv
// types for the boundary test port block
`default_nettype none
package btp_pkg;
   typedef enum logic [15:0] {
      BTP_RESET      = 16'h0001,
      BTP_IDLE       = 16'h0002,
      BTP_SEL_DR     = 16'h0004,
      BTP_CAP_DR     = 16'h0008,
      BTP_SHIFT_DR   = 16'h0010,
      BTP_EXIT1_DR   = 16'h0020,
      BTP_PAUSE_DR   = 16'h0040,
      BTP_EXIT2_DR   = 16'h0080,
      BTP_UPD_DR     = 16'h0100,
      BTP_SEL_IR     = 16'h0200,
      BTP_CAP_IR     = 16'h0400,
      BTP_SHIFT_IR   = 16'h0800,
      BTP_EXIT1_IR   = 16'h1000,
      BTP_PAUSE_IR   = 16'h2000,
      BTP_EXIT2_IR   = 16'h4000,
      BTP_UPD_IR     = 16'h8000
   } btp_state_type;
endpackage
`default_nettype wire

//--- btp_pin_sync.sv
// two-flop synchroniser for one pin
`timescale 1ns/100ps
`default_nettype none
`include "btp_consts.svh"
module btp_pin_sync (
   input  wire logic core_clk_i,
   input  wire logic pin_i,
   input  wire logic init_i,
   input  wire logic rst_i,
   output logic      sync_o
);
   logic [`BTP_SYNC_W-1:0] stage_r;
   logic [`BTP_SYNC_W-1:0] stage_nxt;
   always_comb begin
      stage_nxt = {stage_r[0], pin_i};
      if (rst_i) begin
         stage_nxt = {init_i, init_i};
      end
   end
   always_ff @(posedge core_clk_i) begin
      stage_r <= stage_nxt;
   end
   assign sync_o = stage_r[1];
endmodule // btp_pin_sync
`default_nettype wire

//--- btp_test_port_sva.sv
// concurrent checks on the test port pins
`timescale 1ns/100ps
`default_nettype none
module btp_test_port_sva (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic test_clk_i,
   input wire logic test_mode_sel_i,
   input wire logic test_data_i,
   input wire logic test_reset_n_i,
   input wire logic factory_scan_enable_i,
   input wire logic test_data_o,
   input wire logic test_data_oe_n_o,
   input wire logic port_in_reset_o,
   input wire logic scan_fault_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   a_release_idle: assert property ($fell(rst_i) |-> test_data_oe_n_o && port_in_reset_o)
      else $error("port not idle after reset");
   a_trst_forces: assert property (!test_reset_n_i [*4] |=> port_in_reset_o && test_data_oe_n_o)
      else $error("test reset ignored");
   a_reset_floats: assert property (port_in_reset_o |-> test_data_oe_n_o)
      else $error("output driven in reset state");
   // late change after the pin fall is fine, a change after a rise is not
   a_data_on_fall: assert property ($changed(test_data_o) |-> !$past(test_clk_i, 2))
      else $error("data changed outside low phase");
   a_oe_on_fall: assert property ($changed(test_data_oe_n_o) |-> !$past(test_clk_i, 2))
      else $error("enable changed outside low phase");
   a_fault_sets: assert property (factory_scan_enable_i |-> ##[1:4] scan_fault_o)
      else $error("scan enable not flagged");
   a_fault_sticky: assert property (scan_fault_o |=> scan_fault_o)
      else $error("fault flag dropped");
endmodule // btp_test_port_sva
bind btp_test_port btp_test_port_sva u_sva (.core_clk_i, .rst_i, .test_clk_i, .test_mode_sel_i,
   .test_data_i, .test_reset_n_i, .factory_scan_enable_i, .test_data_o, .test_data_oe_n_o,
   .port_in_reset_o, .scan_fault_o);
`default_nettype wire

//--- btp_ctl_model.sv
// test controller model driving the test port pins
`timescale 1ns/100ps
`default_nettype none
module btp_ctl_model (
   input  wire logic tdo_pin_i,
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
   end
   // one step; held over the rise; clock stands low between steps
   task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
      tms_o = tms_v;
      tdi_o = tdi_v;
      #100 tck_o = 1'b1;
      #98 tdo_v = tdo_pin_i;
      #2 tck_o = 1'b0;
   endtask
endmodule // btp_ctl_model
`default_nettype wire

//--- boundary_test_port_pins_tb.sv
// self-checking bench for the boundary test port
`timescale 1ns/100ps
`default_nettype none
`include "btp_consts.svh"
module boundary_test_port_pins_tb;
   logic core_clk_i, rst_i, trst_n, fse, tdo, oe_n, in_rst, fault, tck, tms, tdi;
   wire  tdo_pin;
   int   miscompares, total_checks, cycles;
   logic [31:0] q;
   assign tdo_pin = oe_n ? 1'bz : tdo;
   btp_test_port dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .test_clk_i(tck),
      .test_mode_sel_i(tms), .test_data_i(tdi), .test_reset_n_i(trst_n),
      .factory_scan_enable_i(fse), .test_data_o(tdo), .test_data_oe_n_o(oe_n),
      .port_in_reset_o(in_rst), .scan_fault_o(fault));
   btp_ctl_model u_ctl (.tdo_pin_i(tdo_pin), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         finish_test();
      end
   end
   // mode select sequence, first bit first
   task automatic walk(input logic [7:0] seq, input int n);
      logic b;
      for (int i = 0; i < n; i++) u_ctl.step(seq[i], 1'b1, b);
   endtask
   task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
      logic b;
      dout = '0;
      for (int i = 0; i < n; i++) begin
         u_ctl.step(i == n - 1, din[i], b);
         dout[i] = b;
      end
   endtask
   task automatic pulse_trst();
      @(posedge core_clk_i) #1 trst_n = 1'b0;
      repeat (6) @(posedge core_clk_i);
      #1;
      check("in_reset", in_rst, 1);
      check("oe_n", oe_n, 1);
      trst_n = 1'b1;
      repeat (4) @(posedge core_clk_i);
      #1;
   endtask
   task automatic t_idcode();
      walk(8'h02, 4);
      shift(32, '0, q);
      check("idcode", q, `BTP_IDCODE_VAL);
      walk(8'h01, 2);
      check("oe_n", oe_n, 1);
      $display("idcode test done");
   endtask
   task automatic t_bypass();
      walk(8'h03, 4);
      shift(4, 32'hf, q);
      check("ir_capture", q, `BTP_IR_CAPTURE);
      walk(8'h01, 2);
      walk(8'h01, 3);
      shift(8, 32'hb5, q);
      check("bypass", {24'h0, q[7:0]}, 32'h6a);
      walk(8'h01, 2);
      $display("bypass test done");
   endtask
   task automatic t_trst_mid();
      walk(8'h01, 3);
      repeat (6) @(posedge core_clk_i);
      #1;
      check("oe_n", oe_n, 0);
      pulse_trst();
      t_idcode();
      $display("mid-shift reset test done");
   endtask
   task automatic t_fault();
      check("fault", fault, 0);
      @(posedge core_clk_i) #1 fse = 1'b1;
      @(posedge core_clk_i) #1 fse = 1'b0;
      repeat (6) @(posedge core_clk_i);
      #1;
      check("fault", fault, 1);
      rst_i = 1'b1;
      repeat (8) @(posedge core_clk_i);
      #1 rst_i = 1'b0;
      @(posedge core_clk_i);
      #1;
      check("fault", fault, 0);
      $display("scan enable test done");
   endtask
   initial begin
      rst_i = 1'b1;
      trst_n = 1'b1;
      fse = 1'b0;
      repeat (8) @(posedge core_clk_i);
      #1 rst_i = 1'b0;
      pulse_trst();
      t_idcode();
      t_bypass();
      t_trst_mid();
      t_fault();
      finish_test();
   end
endmodule // boundary_test_port_pins_tb
`default_nettype wire
